// ---- logic/gpp_map.svh ----
/*
 Register indices, field positions, masks and reset values of the
 general pin port. Included by the pin port design files only.
*/
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// Register indices; the APB byte address is four times the index
`define GPP_IDX_DAT_A    10'h080
`define GPP_IDX_DAT_B    10'h090
`define GPP_IDX_DIR_B    10'h091
`define GPP_IDX_DAT_C    10'h0A0
`define GPP_IDX_DIR_C    10'h0A1
`define GPP_IDX_DIR_A    10'h0A2
`define GPP_IDX_DAT_D    10'h0B0
`define GPP_IDX_MAP_BASE 10'h100
`define GPP_IDX_SEG_BASE 10'h110
`define GPP_IDX_HP_DIR   10'h160
`define GPP_IDX_HP_DAT   10'h164
`define GPP_IDX_OPT      10'h168

// Segment numbering: pin n pairs with segment n + 20
`define GPP_SEG_LO       24
`define GPP_SEG_HI       71
`define GPP_SEG_PAIR     20
`define GPP_MAP_LO_BYTE  3

// Field positions
`define GPP_SEG_DAT_BIT  0
`define GPP_SEG_DIR_BIT  3
`define GPP_HP_DAT_BIT   4
`define GPP_HP_DIR_BIT   7

// Implemented bits of the port registers
`define GPP_DIR_A_MASK   8'hFE
`define GPP_DIR_C_MASK   8'h3A
`define GPP_DAT_D_MASK   8'h6F

// Reset values
`define GPP_BYTE_RST     8'h00
`define GPP_OPT_RST      2'h3

`endif

// ---- logic/gpp_pkg.sv ----
/*
 Types of the general pin port: register select, bank write carrier
 and the state record of the port. No assumptions on surroundings.
*/
package gpp_pkg;

    typedef enum logic [3:0] {
        R_NONE  = 4'b0000,
        R_DAT_A = 4'b0001,
        R_DAT_B = 4'b0010,
        R_DAT_C = 4'b0011,
        R_DAT_D = 4'b0100,
        R_DIR_A = 4'b0101,
        R_DIR_B = 4'b0110,
        R_DIR_C = 4'b0111,
        R_MAP   = 4'b1000,
        R_SEG   = 4'b1001,
        R_HPDIR = 4'b1010,
        R_HPDAT = 4'b1011,
        R_OPT   = 4'b1100
    } gpp_reg_e;

    typedef struct packed {
        logic       we;
        logic [5:0] idx;
        logic [7:0] data;
    } gpp_bwr_s;

    typedef struct packed {
        logic [7:0]  dat_a;
        logic [7:0]  dat_b;
        logic [7:0]  dat_c;
        logic [7:0]  dat_d;
        logic [7:0]  dir_a;
        logic [7:0]  dir_b;
        logic [7:0]  dir_c;
        logic [47:0] map;
        logic [2:0]  hp_dir;
        logic [2:0]  hp_dat;
        logic [1:0]  opt;
        logic [58:0] po;
        logic [58:0] oe;
        logic [31:0] rdata;
        logic        rdy;
        logic        err;
    } gpp_state_s;

endpackage

// ---- logic/gpp_sync.sv ----
/*
 Two-stage synchroniser for a vector of pin levels.
 Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/100ps
module gpp_sync #(
    parameter int W = 59
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds the second stage only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

// ---- logic/gpp_seg_bank.sv ----
/*
 Segment control byte store, one byte per shareable segment.
 Assumes writes come from the port's bus slave with an in-range index.
*/
`timescale 1ns/100ps
`include "gpp_map.svh"
module gpp_seg_bank
    import gpp_pkg::*;
#(
    parameter int N = 48
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire gpp_bwr_s     wr_i,
    input  wire logic [5:0]   ridx_i,
    output logic      [7:0]   rdata_o,
    output logic      [N-1:0] b0_o,
    output logic      [N-1:0] b3_o
);
    if (N < 1 || N > 64) begin : g_chk
        $error("gpp_seg_bank: N out of range");
    end

    logic [7:0] mem_q [N];

    // Cleared so every segment-steered pin starts as an input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N; i++) begin
                mem_q[i] <= `GPP_BYTE_RST;
            end
        end else if (wr_i.we) begin
            mem_q[wr_i.idx] <= wr_i.data;
        end
    end

    assign rdata_o = (int'(ridx_i) < N) ? mem_q[ridx_i] : 8'h00;

    for (genvar k = 0; k < N; k++) begin : g_bit
        assign b0_o[k] = mem_q[k][`GPP_SEG_DAT_BIT];
        assign b3_o[k] = mem_q[k][`GPP_SEG_DIR_BIT];
    end
endmodule

// ---- logic/gpp_port.sv ----
/*
 General pin port with segment sharing, an APB slave with byte registers.
 Assumes a single 100 MHz clock, synchronous reset, asynchronous pin
 inputs and segment drive levels from an external LCD waveform block.
*/
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "gpp_map.svh"
// Overview of operation
// [RQ1] After reset every general pin is input
// [RQ2] Map bit one routes pin to segment
// [RQ3] Direction bit zero input, one output
// [RQ4] Port data registers write outputs, read levels
// [RQ5] Pins 0-15 in groups a, b; push-button bit0
// [RQ6] Direction bits of pins 1-15 in groups a, b
// [RQ7] Pins 16-23 group c; few direction bits
// [RQ8] Pins 24-27, 29, 30 in group d
// [RQ9] No direction register from pin 24 up
// [RQ10] No data register from pin 40 up
// [RQ11] Segment byte bit 3 sets missing directions
// [RQ12] Segment byte bit 0 carries missing data
// [RQ13] Pins 56-58 never share a segment
// [RQ14] Pins 56-58 use own direction, data bytes
// [RQ15] Dedicated pins: 3 and 56-58
// [RQ16] Thirty-seven pins share segment n+20
// [RQ17] Pins 1, 2 general only without optical
// [RQ18] Map bit index equals paired segment number
// [RQ19] Writes stored but inactive until pin outputs
module gpp_port
    import gpp_pkg::*;
#(
    parameter int NPIN = 59,
    parameter int NSEG = 48
) (
    // Clock and reset
    input  wire logic            CLK_SYS_I,
    input  wire logic            RESET_I,
    // APB slave
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [11:0]     PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    // Pins
    input  wire logic [NPIN-1:0] PIN_I,
    output logic      [NPIN-1:0] PIN_O,
    output logic      [NPIN-1:0] PIN_OE_O,
    // Segment drive and optical serial
    input  wire logic [NSEG-1:0] LCD_SEG_I,
    input  wire logic            OPTICAL_SERIAL_TRANSMIT_I,
    output logic                 OPTICAL_SERIAL_RECEIVE_O
);
    if (NPIN != 59 || NSEG != 48) begin : g_chk
        $error("gpp_port: pin map is fixed at 59 pins, 48 segments");
    end

    function automatic bit is_shared(input int n);
        return (n >= 4 && n <= 27) || n == 29 || n == 30 ||
               (n >= 40 && n <= 45) || (n >= 47 && n <= 51);
    endfunction

    function automatic bit has_dir(input int n);
        logic [23:0] m;
        m = {`GPP_DIR_C_MASK, 8'hFF, `GPP_DIR_A_MASK};
        return n < 24 && m[n];
    endfunction

    function automatic bit has_dat(input int n);
        logic [31:0] m;
        m = {`GPP_DAT_D_MASK, 8'hFF, 8'hFF, 8'hFF};
        return n < 32 && m[n];
    endfunction

    function automatic gpp_reg_e decode(input logic [9:0] idx);
        if (idx >= `GPP_IDX_SEG_BASE + 10'(`GPP_SEG_LO) &&
            idx <= `GPP_IDX_SEG_BASE + 10'(`GPP_SEG_HI)) begin
            return R_SEG;
        end
        if (idx >= `GPP_IDX_MAP_BASE + 10'(`GPP_MAP_LO_BYTE) &&
            idx <  `GPP_IDX_MAP_BASE + 10'(`GPP_MAP_LO_BYTE + 6)) begin
            return R_MAP;
        end
        if (idx >= `GPP_IDX_HP_DIR && idx < `GPP_IDX_HP_DIR + 10'h003) begin
            return R_HPDIR;
        end
        if (idx >= `GPP_IDX_HP_DAT && idx < `GPP_IDX_HP_DAT + 10'h003) begin
            return R_HPDAT;
        end
        case (idx)
            `GPP_IDX_DAT_A: return R_DAT_A;
            `GPP_IDX_DAT_B: return R_DAT_B;
            `GPP_IDX_DAT_C: return R_DAT_C;
            `GPP_IDX_DAT_D: return R_DAT_D;
            `GPP_IDX_DIR_A: return R_DIR_A;
            `GPP_IDX_DIR_B: return R_DIR_B;
            `GPP_IDX_DIR_C: return R_DIR_C;
            `GPP_IDX_OPT:   return R_OPT;
            default:        return R_NONE;
        endcase
    endfunction

    gpp_state_s       st;
    gpp_state_s       nx;
    gpp_bwr_s         bwr;
    gpp_reg_e         rsel;
    logic [9:0]       idx;
    logic [5:0]       sidx;
    logic [2:0]       midx;
    logic [1:0]       hidx;
    logic [7:0]       wbyte;
    logic [7:0]       rd_byte;
    logic [7:0]       bank_rd;
    logic             acc;
    logic [NPIN-1:0]  pin_s;
    logic [NPIN-1:0]  dir;
    logic [NPIN-1:0]  val;
    logic [NPIN-1:0]  seg_on;
    logic [NPIN-1:0]  lcd_lvl;
    logic [NPIN-1:0]  gp_out;
    logic [NPIN-1:0]  rb;
    logic [NPIN-1:0]  po_d;
    logic [NPIN-1:0]  oe_d;
    logic [NSEG-1:0]  seg_b0;
    logic [NSEG-1:0]  seg_b3;
    logic [NSEG-1:0]  rb_seg;
    logic [23:0]      dir_sfr;
    logic [31:0]      dat_sfr;

    gpp_sync #(
        .W (NPIN)
    ) u_sync (
        .clk_i (CLK_SYS_I),
        .rst_i (RESET_I),
        .d_i   (PIN_I),
        .q_o   (pin_s)
    );

    gpp_seg_bank #(
        .N (NSEG)
    ) u_bank (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RESET_I),
        .wr_i    (bwr),
        .ridx_i  (sidx),
        .rdata_o (bank_rd),
        .b0_o    (seg_b0),
        .b3_o    (seg_b3)
    );

    assign idx   = PADDR_I[11:2];
    assign rsel  = decode(idx);
    assign acc   = PSEL_I & PENABLE_I;
    assign wbyte = PWDATA_I[7:0];
    assign sidx  = 6'(idx - (`GPP_IDX_SEG_BASE + 10'(`GPP_SEG_LO)));
    assign midx  = 3'(idx - (`GPP_IDX_MAP_BASE + 10'(`GPP_MAP_LO_BYTE)));
    assign hidx  = idx[1:0];

    // Unimplemented bits never act, whatever was written
    assign dir_sfr = {st.dir_c & `GPP_DIR_C_MASK, st.dir_b,
                      st.dir_a & `GPP_DIR_A_MASK};                        // [RQ6] [RQ7]
    assign dat_sfr = {st.dat_d & `GPP_DAT_D_MASK, st.dat_c, st.dat_b, st.dat_a}; // [RQ8]

    for (genvar n = 0; n < NPIN; n++) begin : g_pin
        if (is_shared(n)) begin : g_sh
            // Map bit and segment byte are those of segment n + 20
            assign seg_on[n]  = st.map[n + `GPP_SEG_PAIR - `GPP_SEG_LO];   // [RQ16] [RQ18]
            assign lcd_lvl[n] = LCD_SEG_I[n + `GPP_SEG_PAIR - `GPP_SEG_LO]; // [RQ2]
        end else begin : g_ded
            assign seg_on[n]  = 1'b0;                                     // [RQ13] [RQ15]
            assign lcd_lvl[n] = 1'b0;
        end
        if (has_dir(n)) begin : g_dsfr
            assign dir[n] = dir_sfr[n];                                   // [RQ6] [RQ7]
        end else if (is_shared(n)) begin : g_dseg
            assign dir[n] = seg_b3[n + `GPP_SEG_PAIR - `GPP_SEG_LO];      // [RQ9] [RQ11]
        end else if (n >= 56) begin : g_dhp
            assign dir[n] = st.hp_dir[n - 56];                            // [RQ14]
        end else begin : g_dnone
            assign dir[n] = 1'b0;
        end
        if (has_dat(n)) begin : g_vsfr
            assign val[n] = dat_sfr[n];                                   // [RQ4] [RQ5]
        end else if (is_shared(n)) begin : g_vseg
            assign val[n] = seg_b0[n + `GPP_SEG_PAIR - `GPP_SEG_LO];      // [RQ10] [RQ12]
        end else if (n >= 56) begin : g_vhp
            assign val[n] = st.hp_dat[n - 56];                            // [RQ14]
        end else begin : g_vnone
            assign val[n] = 1'b0;
        end
        if (n == 1 || n == 2) begin : g_opt
            // Optical function owns the pin while selected
            assign gp_out[n] = ~st.opt[n - 1] & dir[n];                   // [RQ17]
        end else begin : g_gp
            assign gp_out[n] = ~seg_on[n] & dir[n];                       // [RQ2] [RQ3]
        end
        // Stored value shows only while the pin is a general output
        assign rb[n] = gp_out[n] ? val[n] : pin_s[n];                     // [RQ19]
        if (n == 2) begin : g_tx
            assign oe_d[n] = st.opt[1] | gp_out[n];                       // [RQ17]
            assign po_d[n] = st.opt[1] ? OPTICAL_SERIAL_TRANSMIT_I : val[n] & gp_out[n];
        end else begin : g_drv
            assign oe_d[n] = seg_on[n] | gp_out[n];                       // [RQ2] [RQ3]
            assign po_d[n] = seg_on[n] ? lcd_lvl[n] : val[n] & gp_out[n]; // [RQ19]
        end
    end

    for (genvar k = 0; k < NSEG; k++) begin : g_seg
        if (is_shared(k + `GPP_SEG_LO - `GPP_SEG_PAIR) &&
            !has_dat(k + `GPP_SEG_LO - `GPP_SEG_PAIR)) begin : g_lvl
            assign rb_seg[k] = rb[k + `GPP_SEG_LO - `GPP_SEG_PAIR];       // [RQ12]
        end else begin : g_raw
            assign rb_seg[k] = seg_b0[k];
        end
    end

    // Read multiplexer
    always_comb begin
        case (rsel)
            R_DAT_A: rd_byte = rb[7:0];                                   // [RQ5]
            R_DAT_B: rd_byte = rb[15:8];
            R_DAT_C: rd_byte = rb[23:16];
            R_DAT_D: rd_byte = rb[31:24] & `GPP_DAT_D_MASK;               // [RQ8]
            R_DIR_A: rd_byte = dir_sfr[7:0];
            R_DIR_B: rd_byte = dir_sfr[15:8];
            R_DIR_C: rd_byte = dir_sfr[23:16];
            R_MAP:   rd_byte = st.map[{midx, 3'b000} +: 8];
            R_SEG:   rd_byte = {bank_rd[7:1], rb_seg[sidx]};
            R_HPDIR: rd_byte = 8'(st.hp_dir[hidx]) << `GPP_HP_DIR_BIT;
            R_HPDAT: rd_byte = 8'(rb[56 + int'(hidx)]) << `GPP_HP_DAT_BIT;
            R_OPT:   rd_byte = {6'h00, st.opt};
            default: rd_byte = 8'h00;
        endcase
    end

    // Next state; one wait state, write lands on the completing edge
    always_comb begin
        nx     = st;
        bwr    = '0;
        nx.rdy = acc & ~st.rdy;
        nx.err = 1'b0;
        if (acc & ~st.rdy) begin
            nx.err   = (rsel == R_NONE);
            nx.rdata = PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
        if (acc & st.rdy & PWRITE_I) begin
            case (rsel)
                R_DAT_A: nx.dat_a = wbyte;                                // [RQ4] [RQ19]
                R_DAT_B: nx.dat_b = wbyte;
                R_DAT_C: nx.dat_c = wbyte;
                R_DAT_D: nx.dat_d = wbyte & `GPP_DAT_D_MASK;
                R_DIR_A: nx.dir_a = wbyte & `GPP_DIR_A_MASK;
                R_DIR_B: nx.dir_b = wbyte;
                R_DIR_C: nx.dir_c = wbyte & `GPP_DIR_C_MASK;
                R_MAP:   nx.map[{midx, 3'b000} +: 8] = wbyte;
                R_SEG: begin
                    bwr.we   = 1'b1;
                    bwr.idx  = sidx;
                    bwr.data = wbyte;
                end
                R_HPDIR: nx.hp_dir[hidx] = wbyte[`GPP_HP_DIR_BIT];        // [RQ14]
                R_HPDAT: nx.hp_dat[hidx] = wbyte[`GPP_HP_DAT_BIT];
                R_OPT:   nx.opt = wbyte[1:0];
                default: bwr.we = 1'b0;
            endcase
        end
        nx.po = po_d;
        nx.oe = oe_d;
    end

    // Everything clears; optical pins come up in optical use
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            st     <= '0;                                                 // [RQ1]
            st.opt <= `GPP_OPT_RST;
        end else begin
            st <= nx;
        end
    end

    assign PRDATA_O  = st.rdata;
    assign PREADY_O  = st.rdy;
    assign PSLVERR_O = st.err;
    assign PIN_O     = st.po;
    assign PIN_OE_O  = st.oe;
    assign OPTICAL_SERIAL_RECEIVE_O  = pin_s[1];

    rst_inputs_a: assert property (@(posedge CLK_SYS_I) RESET_I |=> // [RQ1]
        st.dir_a == 8'h00 && st.dir_b == 8'h00 && st.dir_c == 8'h00 &&
        st.hp_dir == 3'h0 && st.map == '0)
        else $error("direction state not cleared by reset");

    seg_route_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ2]
        st.map[0] |=> st.oe[4] && st.po[4] == $past(LCD_SEG_I[0]))
        else $error("pin 4 not driven by its segment");

    gp_output_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ3]
        !st.map[1] && st.dir_a[5] |=> st.oe[5] && st.po[5] == $past(st.dat_a[5]))
        else $error("pin 5 output wrong");

    gp_input_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ3]
        !st.dir_b[0] && !st.map[4] |=> !st.oe[8])
        else $error("pin 8 driven while input");

    data_write_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ4]
        acc && st.rdy && PWRITE_I && idx == `GPP_IDX_DAT_B
        |=> st.dat_b == $past(PWDATA_I[7:0]))
        else $error("port group b write lost");

    button_read_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ5]
        acc && !st.rdy && !PWRITE_I && idx == `GPP_IDX_DAT_A
        |=> PREADY_O && PRDATA_O[0] == $past(pin_s[0]))
        else $error("push-button level not read");

    seg_dir_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ11]
        !st.map[36] && seg_b3[36] |=> st.oe[40] && st.po[40] == $past(seg_b0[36]))
        else $error("pin 40 not steered by its segment byte");

    high_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ14]
        st.hp_dir[0] |=> st.oe[56] && st.po[56] == $past(st.hp_dat[0]))
        else $error("pin 56 output wrong");

    stored_hidden_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ19]
        !st.dir_a[6] ##1 acc && !st.rdy && !PWRITE_I && idx == `GPP_IDX_DAT_A
        && !st.dir_a[6] |=> PRDATA_O[6] == $past(pin_s[6]))
        else $error("stored value visible on an input pin");

    optical_serial_transmit_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // [RQ17]
        st.opt[1] |=> st.oe[2] && st.po[2] == $past(OPTICAL_SERIAL_TRANSMIT_I))
        else $error("transmit pin not given to optical function");
endmodule

// ---- sim/gpp_board.sv ----
/*
 Board-side model of the general pins: the level seen on every pin.
 Assumes the bench supplies the levels of pins that the port leaves undriven.
*/
`timescale 1ns/100ps
module gpp_board
    import gpp_pkg::*;
(
    // Port side
    input  wire logic [58:0] pin_o_i,
    input  wire logic [58:0] pin_oe_i,
    // Board side
    input  wire logic [58:0] ext_i,
    output logic      [58:0] pin_i_o
);
    // Driven pins read back their own level; no pulls on the board
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ---- sim/test_general_pin_port_with_segment_share.sv ----
/*
 Self-checking bench of the general pin port: APB register calls, pin checks.
 Assumes the board model closes the pin loop and a 100 MHz clock.
*/
`timescale 1ns/100ps
module test_general_pin_port_with_segment_share
    import gpp_pkg::*;
;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [58:0] pin_i;
    logic [58:0] pin_o;
    logic [58:0] pin_oe;
    logic [58:0] ext     = 59'h2;
    logic [47:0] lcd_seg = 48'h0;
    logic        optical_serial_transmit  = 1'b1;
    logic        optical_serial_receive;
    int          num_errors = 0;
    int          compares   = 0;
    int          dseg[6]    = '{44, 45, 46, 47, 49, 50};

    always #5 clk = ~clk;

    gpp_port dut (
        .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE_O(pin_oe), .LCD_SEG_I(lcd_seg), .OPTICAL_SERIAL_TRANSMIT_I(optical_serial_transmit), .OPTICAL_SERIAL_RECEIVE_O(optical_serial_receive)
    );

    gpp_board board (
        .pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .pin_i_o(pin_i)
    );

    task automatic report_and_stop();
        $display("Errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until ready is seen at a rising edge
    task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr_en;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Values read here are those the slave shows at this rising edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("wrong value at %0t: no ready", $time);
            report_and_stop();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, idx, wd, rd, e);
        chk(e, 0, "write error flag");
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic eexp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, idx, 8'h00, rd, e);
        chk(rd, exp, "read data");
        chk(e, eexp, "read error flag");
    endtask

    // Register update plus one edge to the pins, one more into the first sync stage
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("wrong value at %0t: run too long", $time);
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(pin_oe, 59'h4, "reset enables");
        chk(pin_o, 59'h4, "optical transmit drive");
        chk(optical_serial_receive, 1'b1, "optical receive");
        rd_chk(10'h0A2, 32'h0, 1'b0);
        rd_chk(10'h091, 32'h0, 1'b0);
        rd_chk(10'h0A1, 32'h0, 1'b0);
        rd_chk(10'h168, 32'h3, 1'b0);
        wr(10'h168, 8'h00);
        settle();
        chk(pin_oe, 59'h0, "all general inputs");
        // Directions and data of the port groups, pin 3 dedicated
        @(posedge clk) ext[0] <= 1'b1;
        wr(10'h080, 8'h40);
        rd_chk(10'h080, 32'h03, 1'b0);
        wr(10'h0A2, 8'hFF);
        rd_chk(10'h0A2, 32'hFE, 1'b0);
        wr(10'h080, 8'hAA);
        wr(10'h091, 8'hFF);
        wr(10'h090, 8'h5A);
        wr(10'h0A1, 8'hFF);
        rd_chk(10'h0A1, 32'h3A, 1'b0);
        wr(10'h0A0, 8'hC3);
        wr(10'h0B0, 8'hFF);
        settle();
        chk(pin_oe[30:24], 7'h00, "no direction register");
        foreach (dseg[i]) wr(10'(10'h110 + dseg[i]), 8'h08);
        settle();
        chk(pin_oe, 59'h6F3AFFFE, "group enables");
        chk(pin_o, 59'h6F025AAA, "group outputs");
        rd_chk(10'h0A0, 32'h02, 1'b0);
        rd_chk(10'h080, 32'hAB, 1'b0);
        rd_chk(10'h0B0, 32'h6F, 1'b0);
        // Data written while input is kept but not shown
        wr(10'h091, 8'h00);
        ext[15:8] <= 8'h33;
        wr(10'h090, 8'h0F);
        settle();
        rd_chk(10'h090, 32'h33, 1'b0);
        chk({pin_oe[15:8], pin_o[15:8]}, 16'h0000, "held back");
        wr(10'h091, 8'hFF);
        settle();
        chk(pin_o[15:8], 8'h0F, "stored value driven");
        // Pin 40 through its segment byte only
        @(posedge clk) ext[40] <= 1'b1;
        wr(10'h14C, 8'h00);
        settle();
        rd_chk(10'h14C, 32'h01, 1'b0);
        wr(10'h14C, 8'h09);
        settle();
        chk({pin_oe[40], pin_o[40]}, 2'b11, "pin 40 drive");
        wr(10'h14C, 8'h08);
        settle();
        rd_chk(10'h14C, 32'h08, 1'b0);
        // Segment routing at both ends of the map
        @(posedge clk) lcd_seg[0] <= 1'b1;
        lcd_seg[47] <= 1'b1;
        wr(10'h103, 8'h01);
        wr(10'h108, 8'h80);
        settle();
        chk({pin_oe[51], pin_o[51], pin_o[4], pin_o[6]}, 4'b1110, "segment routing");
        rd_chk(10'h108, 32'h80, 1'b0);
        @(posedge clk) lcd_seg[0] <= 1'b0;
        settle();
        chk(pin_o[4], 1'b0, "segment level follows");
        // Dedicated high pins
        for (int k = 0; k < 3; k++) wr(10'(10'h160 + k), 8'h80);
        wr(10'h164, 8'h10);
        wr(10'h166, 8'h10);
        settle();
        chk({pin_oe[58:56], pin_o[58:56]}, 6'b111101, "high pins");
        rd_chk(10'h160, 32'h80, 1'b0);
        rd_chk(10'h164, 32'h10, 1'b0);
        rd_chk(10'h3FF, 32'h0, 1'b1);
        report_and_stop();
    end
endmodule
